// ---- mmcl_params.svh ----
// Summary of operation
// - capture all parameters at power-up and reset
// - true parameter is bit 1, false 0
// - mode parameters fixed, not changed at run
// - other parameters seed register reset defaults
// - enabled host may read all registers and overwrite PHYCTL and MGMT; MODE is read-only
// - host port parameter makes registers usable
// - no host: management serial follows parameter
// - host and parameter: enable bit gates serial
// - transmit client 16 bits wide or 8
// - receive client 16 bits wide or 8
// - one phy select at most; none means MII/GMII
// - serial gig allows run-time 1000BASE-X switch
// - reduced gig select gives RGMII operation
// - serial gig select gives SGMII operation
// - gig x select gives 1000BASE-X operation
// - asynchronous reset starts capture, clears all
`ifndef MMCL_PARAMS_SVH
`define MMCL_PARAMS_SVH
// ==========================================
// register byte offsets
`define MMCL_OFS_MODE 4'h0
`define MMCL_OFS_PHYCTL 4'h4
`define MMCL_OFS_MGMT 4'h8
`define MMCL_ADDR_W 4
// ==========================================
// field positions
`define MMCL_BIT_HOST 0
`define MMCL_BIT_MGMTP 1
`define MMCL_BIT_TXW 2
`define MMCL_BIT_RXW 3
`define MMCL_BIT_PHYLO 4
`define MMCL_BIT_ERR 6
`define MMCL_BIT_VALID 7
`define MMCL_BIT_BASEX 0
`define MMCL_BIT_MGMTEN 0
// ==========================================
// responses and counts
`define MMCL_RESP_OKAY 2'h0
`define MMCL_RESP_SLVERR 2'h2
`define MMCL_RESP_DECERR 2'h3
`define MMCL_SYNC_WAIT 2'h2
`endif

// ---- mmcl_pkg.sv ----
package mmcl_pkg;
  // physical interface operating mode
  typedef enum logic [1:0] {
    MMCL_PHY_MII_GMII = 2'h0,
    MMCL_PHY_RGMII = 2'h1,
    MMCL_PHY_SGMII = 2'h2,
    MMCL_PHY_BASEX = 2'h3
  } mmcl_phy_t;

  // raw configuration parameter levels
  typedef struct packed {
    logic host_port_enable_param;
    logic mgmt_serial_enable_param;
    logic tx_client_wide_param;
    logic rx_client_wide_param;
    logic reduced_gig_phy_select_param;
    logic serial_gig_phy_select_param;
    logic gig_x_pcs_select_param;
  } mmcl_straps_t;

  // decoded settings handed to the mac
  typedef struct packed {
    logic host_port_en;
    logic mgmt_serial_en;
    logic tx_client_wide;
    logic rx_client_wide;
    mmcl_phy_t phy_mode;
    logic cfg_err;
    logic cfg_valid;
  } mmcl_mode_t;
endpackage

// ---- mmcl_loader.sv ----
`timescale 1ns/1ps
`include "mmcl_params.svh"
module mmcl_loader
  import mmcl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire mmcl_straps_t straps,
  output mmcl_mode_t mode,
  input wire logic [`MMCL_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`MMCL_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================
  // parameter synchroniser
  mmcl_straps_t strap_s1_r; // first stage, read only by stage two
  mmcl_straps_t strap_s2_r; // settled parameter levels

  // straps come from pins, so two flops before use
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strap_s1_r <= '0;
      strap_s2_r <= '0;
    end
    else
    begin
      strap_s1_r <= straps;
      strap_s2_r <= strap_s1_r;
    end
  end

  // ==========================================
  // capture sequencer
  typedef enum logic [1:0] {ST_FILL, ST_LOAD, ST_RUN} mmcl_state_t;
  mmcl_state_t state_r; // loader phase
  logic [1:0] fill_cnt_r; // cycles spent filling the synchroniser

  // reset forces a fresh load every time
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= ST_FILL;
      fill_cnt_r <= 2'h0;
    end
    else
    begin
      case (state_r)
        // wait until sampled straps are real, not reset zeros
        ST_FILL:
        begin
          fill_cnt_r <= fill_cnt_r + 2'h1;
          if (fill_cnt_r == `MMCL_SYNC_WAIT)
          begin
            state_r <= ST_LOAD;
          end
        end
        // single load cycle
        ST_LOAD:
        begin
          state_r <= ST_RUN;
        end
        // held until the next reset
        ST_RUN:
        begin
          state_r <= ST_RUN;
        end
        default:
        begin
          state_r <= ST_FILL;
        end
      endcase
    end
  end

  wire logic load_now = (state_r == ST_LOAD); // capture strobe

  // ==========================================
  // static mode state
  mmcl_straps_t cap_r; // captured parameter bits
  mmcl_phy_t phy_base_r; // decoded fixed phy mode
  logic cfg_err_r; // more than one phy select was set
  logic cfg_valid_r; // capture has completed

  // conflicting selects count as error
  wire logic [1:0] sel_cnt = 2'({1'b0, strap_s2_r.reduced_gig_phy_select_param})
    + 2'({1'b0, strap_s2_r.serial_gig_phy_select_param})
    + 2'({1'b0, strap_s2_r.gig_x_pcs_select_param});

  // decode only at load, never at run time
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cap_r <= '0;
      phy_base_r <= MMCL_PHY_MII_GMII;
      cfg_err_r <= 1'b0;
      cfg_valid_r <= 1'b0;
    end
    else if (load_now)
    begin
      cap_r <= strap_s2_r;
      cfg_valid_r <= 1'b1;
      cfg_err_r <= (sel_cnt > 2'h1);
      // an error falls back to the safe default, flagged above
      if (sel_cnt != 2'h1)
      begin
        phy_base_r <= MMCL_PHY_MII_GMII;
      end
      else if (strap_s2_r.reduced_gig_phy_select_param)
      begin
        phy_base_r <= MMCL_PHY_RGMII;
      end
      else if (strap_s2_r.serial_gig_phy_select_param)
      begin
        phy_base_r <= MMCL_PHY_SGMII;
      end
      else
      begin
        phy_base_r <= MMCL_PHY_BASEX;
      end
    end
  end

  // ==========================================
  // host-writable control registers
  logic basex_sel_r; // run-time 1000BASE-X choice on serial gig
  logic mgmt_cfg_en_r; // management serial enable bit
  logic wr_do; // write commits this cycle
  logic [`MMCL_ADDR_W-1:0] aw_addr_r; // held write address
  logic [31:0] w_data_r; // held write data
  logic [3:0] w_strb_r; // held byte enables
  logic wr_ok; // host may change registers

  assign wr_ok = cap_r.host_port_enable_param & cfg_valid_r;

  // defaults come from parameters at load
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      basex_sel_r <= 1'b0;
      mgmt_cfg_en_r <= 1'b0;
    end
    else if (load_now)
    begin
      basex_sel_r <= strap_s2_r.gig_x_pcs_select_param;
      mgmt_cfg_en_r <= strap_s2_r.mgmt_serial_enable_param;
    end
    else if (wr_do && wr_ok && w_strb_r[0])
    begin
      // host overwrites the loaded default
      if (aw_addr_r == `MMCL_OFS_MGMT)
      begin
        mgmt_cfg_en_r <= w_data_r[`MMCL_BIT_MGMTEN];
      end
      // only a serial gig build may switch
      else if (aw_addr_r == `MMCL_OFS_PHYCTL && cap_r.serial_gig_phy_select_param && !cfg_err_r)
      begin
        basex_sel_r <= w_data_r[`MMCL_BIT_BASEX];
      end
    end
  end

  // ==========================================
  // decoded outputs, all registered
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode <= '0;
    end
    else
    begin
      mode.host_port_en <= cap_r.host_port_enable_param;
      mode.tx_client_wide <= cap_r.tx_client_wide_param;
      mode.rx_client_wide <= cap_r.rx_client_wide_param;
      mode.cfg_err <= cfg_err_r;
      mode.cfg_valid <= cfg_valid_r;
      // fixed without host, gated by bit with host
      if (cap_r.host_port_enable_param)
      begin
        mode.mgmt_serial_en <= cap_r.mgmt_serial_enable_param & mgmt_cfg_en_r;
      end
      else
      begin
        mode.mgmt_serial_en <= cap_r.mgmt_serial_enable_param;
      end
      // serial gig may swap to 1000BASE-X at run time
      if (phy_base_r == MMCL_PHY_SGMII && basex_sel_r)
      begin
        mode.phy_mode <= MMCL_PHY_BASEX;
      end
      else
      begin
        mode.phy_mode <= phy_base_r;
      end
    end
  end

  // ==========================================
  // bus write channel
  logic aw_got_r; // address held
  logic w_got_r; // data held

  assign wr_do = aw_got_r & w_got_r & ~s_axi_bvalid;

  // address and data taken in either order
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      // address side
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      else if (wr_do)
      begin
        aw_got_r <= 1'b0;
      end
      else if (!aw_got_r && !s_axi_bvalid)
      begin
        s_axi_awready <= 1'b1;
      end
      // data side
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      else if (wr_do)
      begin
        w_got_r <= 1'b0;
      end
      else if (!w_got_r && !s_axi_bvalid)
      begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // write response after both halves
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MMCL_RESP_OKAY;
    end
    else if (wr_do)
    begin
      s_axi_bvalid <= 1'b1;
      // no host port means registers are read-only
      if (aw_addr_r != `MMCL_OFS_MODE && aw_addr_r != `MMCL_OFS_PHYCTL && aw_addr_r != `MMCL_OFS_MGMT)
      begin
        s_axi_bresp <= `MMCL_RESP_DECERR;
      end
      else if (!wr_ok || aw_addr_r == `MMCL_OFS_MODE)
      begin
        s_axi_bresp <= `MMCL_RESP_SLVERR;
      end
      else
      begin
        s_axi_bresp <= `MMCL_RESP_OKAY;
      end
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================
  // bus read channel
  logic [31:0] rd_word; // selected register image

  // reads always allowed so state stays visible
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      `MMCL_OFS_MODE:
      begin
        rd_word[`MMCL_BIT_HOST] = cap_r.host_port_enable_param;
        rd_word[`MMCL_BIT_MGMTP] = cap_r.mgmt_serial_enable_param;
        rd_word[`MMCL_BIT_TXW] = cap_r.tx_client_wide_param;
        rd_word[`MMCL_BIT_RXW] = cap_r.rx_client_wide_param;
        rd_word[`MMCL_BIT_PHYLO+1:`MMCL_BIT_PHYLO] = mode.phy_mode;
        rd_word[`MMCL_BIT_ERR] = cfg_err_r;
        rd_word[`MMCL_BIT_VALID] = cfg_valid_r;
      end
      `MMCL_OFS_PHYCTL:
      begin
        rd_word[`MMCL_BIT_BASEX] = basex_sel_r;
      end
      `MMCL_OFS_MGMT:
      begin
        rd_word[`MMCL_BIT_MGMTEN] = mgmt_cfg_en_r;
      end
      default:
      begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // one read in flight; ready returns after the data is taken
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `MMCL_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      // unmapped address answers decode error
      if (s_axi_araddr == `MMCL_OFS_MODE || s_axi_araddr == `MMCL_OFS_PHYCTL
          || s_axi_araddr == `MMCL_OFS_MGMT)
      begin
        s_axi_rresp <= `MMCL_RESP_OKAY;
      end
      else
      begin
        s_axi_rresp <= `MMCL_RESP_DECERR;
      end
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
    else
    begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule // mmcl_loader

// ---- mmcl_loader_props.sv ----
`timescale 1ns/1ps
// ========================================
// pin-level checks beside the loader
module mmcl_loader_props
  import mmcl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire mmcl_straps_t straps,
  input wire mmcl_mode_t mode,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // one clock domain, so one default clock and reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // ========================================
  // bus answers
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  a_no_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while answer pending");
  // ========================================
  // decoded mode
  a_load_bound: assert property ($rose(rst_b) |-> ##[1:8] mode.cfg_valid)
    else $error("capture not done after reset");
  a_width_follow: assert property (mode.cfg_valid |-> mode.tx_client_wide == straps.tx_client_wide_param
    && mode.rx_client_wide == straps.rx_client_wide_param)
    else $error("client width wrong");
  a_fixed_mgmt: assert property (mode.cfg_valid && !mode.host_port_en
    |-> mode.mgmt_serial_en == straps.mgmt_serial_enable_param)
    else $error("serial enable not fixed");
  a_err_fallback: assert property (mode.cfg_err |-> mode.phy_mode == MMCL_PHY_MII_GMII)
    else $error("conflict not fallen back");
  a_rgmii_mode: assert property (mode.cfg_valid && straps.reduced_gig_phy_select_param
    && !straps.serial_gig_phy_select_param && !straps.gig_x_pcs_select_param
    |-> mode.phy_mode == MMCL_PHY_RGMII)
    else $error("rgmii not selected");
  // modes frozen between resets; host writes touch none of these
  a_mode_stable: assert property (mode.cfg_valid |=> $stable({mode.host_port_en, mode.tx_client_wide,
    mode.rx_client_wide, mode.cfg_err}))
    else $error("static mode changed");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_conflict: cover property (mode.cfg_err);
  c_basex: cover property (mode.cfg_valid && mode.phy_mode == MMCL_PHY_BASEX);
endmodule // mmcl_loader_props
bind mmcl_loader mmcl_loader_props u_props (.*);

// ---- mmcl_host_model.sv ----
`timescale 1ns/1ps
`include "mmcl_params.svh"
// ========================================
// host software seen as an axi4-lite master
module mmcl_host_model (
  input wire logic ref_clk,
  output logic [`MMCL_ADDR_W-1:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [`MMCL_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // bus idle from time zero
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
  end
  // one write; each half dropped once taken, no cycle count assumed
  task automatic wr(input logic [`MMCL_ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // one read; answer taken at the edge rvalid is seen
  task automatic rd(input logic [`MMCL_ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule // mmcl_host_model

// ---- mmcl_loader_bench.sv ----
`timescale 1ns/1ps
`include "mmcl_params.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin $display("FAIL %s exp %0h got %0h", nm, e, g); num_errors++; end end
module mmcl_loader_bench import mmcl_pkg::*;;
  logic ref_clk, rst_b;
  mmcl_straps_t straps;
  mmcl_mode_t mode;
  logic [`MMCL_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] em;
  logic [6:0] es;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  // ========================================
  // rows: strap levels beside the mode they give
  typedef struct packed { mmcl_straps_t s; mmcl_mode_t m; } mmcl_row_t;
  mmcl_row_t rows [6] = '{'{7'h00, 8'h01}, '{7'h34, 8'h65}, '{7'h6A, 8'hD9},
    '{7'h51, 8'hAD}, '{7'h0E, 8'h13}, '{7'h7F, 8'hF3}};
  mmcl_loader DUT (.*);
  mmcl_host_model host (.*);
  // 25 ns clock
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      num_errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // straps move only while reset is held
  task automatic restart(input mmcl_straps_t s);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    straps <= s;
    repeat (4) @(posedge ref_clk);
    `CHK("mode in reset", 8'h00, mode)
    rst_b <= 1'b1;
    repeat (10) @(posedge ref_clk);
  endtask
  // ========================================
  // main sequence
  initial
  begin
    rst_b = 1'b0;
    straps = '0;
    foreach (rows[i])
    begin
      restart(rows[i].s);
      `CHK("mode", rows[i].m, mode)
      em = rows[i].m;
      es = rows[i].s;
      host.rd(`MMCL_OFS_MODE, rd_data, resp);
      `CHK("mode reg", {24'h0, em[0], em[1], em[3:2], em[4], em[5], es[5], es[6]}, rd_data)
    end
    // host port on: defaults seeded, then overwritten
    restart(7'h6A);
    host.rd(`MMCL_OFS_MGMT, rd_data, resp);
    `CHK("mgmt default", 32'h1, rd_data)
    host.wr(`MMCL_OFS_PHYCTL, 32'h1, resp);
    `CHK("phyctl resp", `MMCL_RESP_OKAY, resp)
    repeat (2) @(posedge ref_clk);
    `CHK("basex switch", MMCL_PHY_BASEX, mode.phy_mode)
    host.wr(`MMCL_OFS_MGMT, 32'h0, resp);
    repeat (2) @(posedge ref_clk);
    `CHK("mgmt off", 1'b0, mode.mgmt_serial_en)
    host.wr(`MMCL_OFS_MODE, 32'hFF, resp);
    `CHK("mode write", `MMCL_RESP_SLVERR, resp)
    host.rd(4'hC, rd_data, resp);
    `CHK("unmapped", `MMCL_RESP_DECERR, resp)
    `CHK("unmapped data", 32'h0, rd_data)
    restart(7'h6A);
    `CHK("reload", 8'hD9, mode)
    // host port off: serial enable fixed
    restart(7'h20);
    host.wr(`MMCL_OFS_MGMT, 32'h0, resp);
    `CHK("no host write", `MMCL_RESP_SLVERR, resp)
    repeat (2) @(posedge ref_clk);
    `CHK("fixed mgmt", 1'b1, mode.mgmt_serial_en)
    // two selects: flagged, phy switch locked
    restart(7'h43);
    host.wr(`MMCL_OFS_PHYCTL, 32'h0, resp);
    `CHK("locked phyctl resp", `MMCL_RESP_OKAY, resp)
    host.rd(`MMCL_OFS_PHYCTL, rd_data, resp);
    `CHK("phyctl locked", 32'h1, rd_data)
    // enable bit set, but parameter false keeps serial off
    host.wr(`MMCL_OFS_MGMT, 32'h1, resp);
    host.rd(`MMCL_OFS_MGMT, rd_data, resp);
    `CHK("mgmt bit set", 32'h1, rd_data)
    repeat (2) @(posedge ref_clk);
    `CHK("gated mgmt", 1'b0, mode.mgmt_serial_en)
    `CHK("conflict", 8'h83, mode)
    close_out();
  end
endmodule // mmcl_loader_bench
